// ===== hdl/switch_status_control_regs.sv
// Behaviour
// - The status register shows a read-only 3-bit operating mode from pins: 0 normal, 1 with EEPROM load, rest reserved.
// - Status bit 5 reads the downstream common-clock strap caught at the last fundamental reset.
// - Status bit 6 reads the upstream common-clock strap caught at the last fundamental reset.
// - Status bit 7 reads the master SMBus slow-mode strap caught at fundamental reset, read-only.
// - Status bit 8 reads the reference clock mode strap caught at fundamental reset, read-only.
// - Status bit 9 reads the reset-halt strap caught at fundamental reset, read-only.
// - Status bits 22:20 report the upstream lock state read-only, reset to zero.
// - The 4-bit marker in bits 31:28 resets to zero and is kept unchanged across hot reset.
// - Writing one to control bit 0 starts a fundamental reset.
// - Writing zero to control bit 0 does nothing and the bit always reads zero.
// - The marker accepts writes only while the register unlock bit is set, else it is read-only.
`include "switch_regs_params.svh"
`default_nettype none
module switch_status_control_regs #(
  parameter int ADDR_WIDTH = `SW_ADDR_WIDTH,
  parameter int FUNDAMENTAL_RESET_TRIGGER_CYCLES = `FUNDAMENTAL_RESET_TRIGGER_PULSE_CYCLES
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // fundamental reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [ADDR_WIDTH-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [2:0] operating_mode_straps, // mode pins
  input wire logic common_clock_downstream, // downstream common clock strap
  input wire logic common_clock_upstream, // upstream common clock strap
  input wire logic master_smbus_slow_select, // master smbus slow strap
  input wire logic reference_clock_mode, // reference clock mode strap
  input wire logic reset_halt_strap, // reset halt strap
  input wire switch_regs_pkg::lock_state_type upstream_lock_state, // live lock state
  input wire logic hot_reset, // hot reset in progress, active high
  output logic fundamental_reset_trigger, // fundamental reset request pulse
  output switch_regs_pkg::operating_mode_type operating_mode, // captured mode
  output logic reset_halt_active // captured reset halt strap
);
  import switch_regs_pkg::*;

  localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR = ADDR_WIDTH'(`SW_STATUS_OFFSET);
  localparam logic [ADDR_WIDTH-1:0] CONTROL_ADDR = ADDR_WIDTH'(`SW_CONTROL_OFFSET);

  logic [`STRAP_WIDTH-1:0] strap_bundle;
  logic [`STRAP_WIDTH-1:0] strap_q;
  logic strap_valid;
  lock_state_type lock_q;
  marker_type marker_q;
  logic unlock_q;
  logic fundamental_reset_trigger_start_q;
  logic fund_request;
  logic setup;
  logic access_done;
  logic wr_done;
  logic hit_status;
  logic hit_control;
  logic [31:0] status_word;
  logic [31:0] control_word;
  logic [31:0] read_mux;

  assign strap_bundle = {reset_halt_strap, reference_clock_mode, master_smbus_slow_select,
                         common_clock_upstream, common_clock_downstream, operating_mode_straps};

  strap_capture #(
    .WIDTH(`STRAP_WIDTH)
  ) u_strap_capture (
    .pclk(pclk),
    .presetn(presetn),
    .straps(strap_bundle),
    .captured(strap_q),
    .captured_valid(strap_valid)
  );

  fundamental_reset_pulse #(
    .CYCLES(FUNDAMENTAL_RESET_TRIGGER_CYCLES)
  ) u_fundamental_reset_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .start(fundamental_reset_trigger_start_q),
    .request(fund_request)
  );

  assign setup = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite;
  assign hit_status = paddr == STATUS_ADDR;
  assign hit_control = paddr == CONTROL_ADDR;

  // status word assembly; reserved bits read zero
  always_comb begin
    status_word = `DATA_ZERO;
    status_word[`MODE_MSB:`MODE_LSB] = strap_q[2:0];
    status_word[`CCLK_DS_BIT] = strap_q[3];
    status_word[`CCLK_US_BIT] = strap_q[4];
    status_word[`SMBUS_SLOW_BIT] = strap_q[5];
    status_word[`REFCLK_MODE_BIT] = strap_q[6];
    status_word[`RESET_HALT_BIT] = strap_q[7];
    status_word[`LOCK_MSB:`LOCK_LSB] = lock_q;
    status_word[`MARKER_MSB:`MARKER_LSB] = marker_q;
  end

  // trigger bit is never stored, so it reads zero
  always_comb begin
    control_word = `DATA_ZERO;
    control_word[`FUNDAMENTAL_RESET_TRIGGER_BIT] = 1'b0;
    control_word[`UNLOCK_BIT] = unlock_q;
  end

  always_comb begin
    if (hit_status) begin
      read_mux = status_word;
    end else if (hit_control) begin
      read_mux = control_word;
    end else begin
      read_mux = `DATA_ZERO;
    end
  end

  // answer is prepared in the setup cycle so the first access cycle completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `DATA_ZERO;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= !(hit_status || hit_control);
      prdata <= pwrite ? `DATA_ZERO : read_mux;
    end else if (access_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `DATA_ZERO;
    end
  end

  // lock state follows the switch, cleared while hot reset is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= `LOCK_RESET;
    end else if (hot_reset) begin
      lock_q <= `LOCK_RESET;
    end else begin
      lock_q <= upstream_lock_state;
    end
  end

  // marker is untouched by hot reset and only writable when unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker_q <= `MARKER_RESET;
    end else if (wr_done && hit_status && unlock_q) begin
      marker_q <= pwdata[`MARKER_MSB:`MARKER_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= `UNLOCK_RESET;
    end else if (wr_done && hit_control) begin
      unlock_q <= pwdata[`UNLOCK_BIT];
    end
  end

  // a written one fires a single start; a written zero has no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fundamental_reset_trigger_start_q <= 1'b0;
    end else begin
      fundamental_reset_trigger_start_q <= wr_done && hit_control && pwdata[`FUNDAMENTAL_RESET_TRIGGER_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fundamental_reset_trigger <= 1'b0;
      operating_mode <= MODE_NORMAL;
      reset_halt_active <= 1'b0;
    end else begin
      fundamental_reset_trigger <= fund_request;
      operating_mode <= operating_mode_type'(strap_q[2:0]);
      reset_halt_active <= strap_q[7];
    end
  end

  logic rd_status;
  logic rd_control;
  assign rd_status = access_done && !pwrite && hit_status;
  assign rd_control = access_done && !pwrite && hit_control;

  property p_mode_read;
    @(posedge pclk) disable iff (!presetn)
    rd_status |-> prdata[`MODE_MSB:`MODE_LSB] == strap_q[2:0];
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode field mismatch");

  property p_mode_out;
    @(posedge pclk) disable iff (!presetn)
    strap_valid ##1 strap_valid |-> operating_mode == $past(strap_q[2:0]);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode output mismatch");

  property p_cclk_ds;
    @(posedge pclk) disable iff (!presetn)
    rd_status |-> prdata[`CCLK_DS_BIT] == strap_q[3];
  endproperty
  a_cclk_ds: assert property (p_cclk_ds) else $error("downstream clock bit mismatch");

  property p_cclk_us;
    @(posedge pclk) disable iff (!presetn)
    rd_status |-> prdata[`CCLK_US_BIT] == strap_q[4];
  endproperty
  a_cclk_us: assert property (p_cclk_us) else $error("upstream clock bit mismatch");

  property p_smbus;
    @(posedge pclk) disable iff (!presetn)
    rd_status |-> prdata[`SMBUS_SLOW_BIT] == strap_q[5];
  endproperty
  a_smbus: assert property (p_smbus) else $error("smbus slow bit mismatch");

  property p_refclk;
    @(posedge pclk) disable iff (!presetn)
    rd_status |-> prdata[`REFCLK_MODE_BIT] == strap_q[6];
  endproperty
  a_refclk: assert property (p_refclk) else $error("refclk mode bit mismatch");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    rd_status |-> prdata[`RESET_HALT_BIT] == strap_q[7];
  endproperty
  a_halt: assert property (p_halt) else $error("reset halt bit mismatch");

  property p_lock_hot;
    @(posedge pclk) disable iff (!presetn)
    hot_reset |=> lock_q == `LOCK_RESET;
  endproperty
  a_lock_hot: assert property (p_lock_hot) else $error("lock not cleared by hot reset");

  property p_lock_follow;
    @(posedge pclk) disable iff (!presetn)
    !hot_reset |=> lock_q == $past(upstream_lock_state);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock does not follow");

  property p_marker_hot;
    @(posedge pclk) disable iff (!presetn)
    hot_reset && !(wr_done && hit_status) |=> $stable(marker_q);
  endproperty
  a_marker_hot: assert property (p_marker_hot) else $error("marker changed in hot reset");

  property p_fundamental_reset_trigger_start;
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit_control && pwdata[`FUNDAMENTAL_RESET_TRIGGER_BIT] && !fund_request
      |-> ##[2:3] fundamental_reset_trigger;
  endproperty
  a_fundamental_reset_trigger_start: assert property (p_fundamental_reset_trigger_start) else $error("reset request not raised");

  property p_fundamental_reset_trigger_zero;
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit_control && !pwdata[`FUNDAMENTAL_RESET_TRIGGER_BIT] |=> !fundamental_reset_trigger_start_q;
  endproperty
  a_fundamental_reset_trigger_zero: assert property (p_fundamental_reset_trigger_zero) else $error("zero write started a reset");

  property p_fundamental_reset_trigger_read;
    @(posedge pclk) disable iff (!presetn)
    rd_control |-> !prdata[`FUNDAMENTAL_RESET_TRIGGER_BIT];
  endproperty
  a_fundamental_reset_trigger_read: assert property (p_fundamental_reset_trigger_read) else $error("trigger bit read as one");

  property p_marker_locked;
    @(posedge pclk) disable iff (!presetn)
    !unlock_q |=> $stable(marker_q);
  endproperty
  a_marker_locked: assert property (p_marker_locked) else $error("marker written when locked");

  property p_marker_write;
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit_status && unlock_q |=> marker_q == $past(pwdata[`MARKER_MSB:`MARKER_LSB]);
  endproperty
  a_marker_write: assert property (p_marker_write) else $error("marker write lost");

  property p_strap_hold;
    @(posedge pclk) disable iff (!presetn)
    strap_valid |=> $stable(strap_q) && strap_valid;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("captured straps changed");

  property p_strap_capture;
    @(posedge pclk) disable iff (!presetn)
    !strap_valid |=> strap_valid && strap_q == $past(strap_bundle);
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("straps not captured");
endmodule
`default_nettype wire

// ===== include/switch_regs_params.svh
`ifndef SWITCH_REGS_PARAMS_SVH
`define SWITCH_REGS_PARAMS_SVH

// register byte offsets
`define SW_STATUS_OFFSET 12'h328
`define SW_CONTROL_OFFSET 12'h32c
`define SW_ADDR_WIDTH 12

// switch_status field positions
`define MODE_LSB 0
`define MODE_MSB 2
`define CCLK_DS_BIT 5
`define CCLK_US_BIT 6
`define SMBUS_SLOW_BIT 7
`define REFCLK_MODE_BIT 8
`define RESET_HALT_BIT 9
`define LOCK_LSB 20
`define LOCK_MSB 22
`define MARKER_LSB 28
`define MARKER_MSB 31

// switch_control field positions
`define FUNDAMENTAL_RESET_TRIGGER_BIT 0
`define UNLOCK_BIT 3

// reset values
`define LOCK_RESET 3'h0
`define MARKER_RESET 4'h0
`define UNLOCK_RESET 1'h0
`define STRAP_RESET 8'h00
`define DATA_ZERO 32'h0000_0000

// strap bundle layout: {halt, refclk, smbus, cclk_us, cclk_ds, mode[2:0]}
`define STRAP_WIDTH 8

// length of the fundamental reset request pulse, in pclk cycles
`define FUNDAMENTAL_RESET_TRIGGER_PULSE_CYCLES 16

`endif

// ===== include/switch_regs_pkg.sv
`default_nettype none
package switch_regs_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_NORMAL_EEPROM = 3'h1
  } operating_mode_type;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b01,
    PULSE_ACTIVE = 2'b10
  } pulse_state_type;

  typedef logic [2:0] lock_state_type;
  typedef logic [3:0] marker_type;
endpackage
`default_nettype wire

// ===== hdl/strap_capture.sv
`include "switch_regs_params.svh"
`default_nettype none
module strap_capture #(
  parameter int WIDTH = `STRAP_WIDTH
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // fundamental reset, active low
  input wire logic [WIDTH-1:0] straps, // live strap pins
  output logic [WIDTH-1:0] captured, // strap values frozen at release
  output logic captured_valid // high once the capture has happened
);
  import switch_regs_pkg::*;

  // flops take only constants under reset; the pins are sampled at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured <= WIDTH'(`STRAP_RESET);
      captured_valid <= 1'b0;
    end else if (!captured_valid) begin
      captured <= straps;
      captured_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/fundamental_reset_pulse.sv
`include "switch_regs_params.svh"
`default_nettype none
module fundamental_reset_pulse #(
  parameter int CYCLES = `FUNDAMENTAL_RESET_TRIGGER_PULSE_CYCLES
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // fundamental reset, active low
  input wire logic start, // one-cycle trigger
  output logic request // fundamental reset request, high for CYCLES cycles
);
  import switch_regs_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  pulse_state_type state_q;
  logic [CW-1:0] count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PULSE_IDLE;
      count_q <= '0;
      request <= 1'b0;
    end else begin
      case (state_q)
        PULSE_IDLE: begin
          if (start) begin
            state_q <= PULSE_ACTIVE;
            count_q <= '0;
            request <= 1'b1;
          end
        end
        PULSE_ACTIVE: begin
          if (count_q == LAST) begin
            state_q <= PULSE_IDLE;
            request <= 1'b0;
          end else begin
            count_q <= count_q + CW'(1);
          end
        end
        default: begin
          state_q <= PULSE_IDLE;
          request <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/switch_status_control_regs_test.sv
`default_nettype none
module switch_status_control_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import switch_regs_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [2:0] lock;
    logic [31:0] exp;
    logic err;
  } row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] operating_mode_straps = 3'h1;
  logic common_clock_downstream = 1'b1;
  logic common_clock_upstream = 1'b0;
  logic master_smbus_slow_select = 1'b1;
  logic reference_clock_mode = 1'b0;
  logic reset_halt_strap = 1'b1;
  lock_state_type upstream_lock_state = 3'h0;
  logic hot_reset = 1'b0;
  logic fundamental_reset_trigger;
  operating_mode_type operating_mode;
  logic reset_halt_active;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  int cnt;
  row_type rows [16] = '{
    '{1'b0, 12'h32c, 32'h0, 3'h0, 32'h0000_0000, 1'b0},
    '{1'b1, 12'h328, 32'ha000_0000, 3'h0, 32'h0, 1'b0},
    '{1'b0, 12'h328, 32'h0, 3'h0, 32'h0000_02a1, 1'b0},
    '{1'b1, 12'h32c, 32'h0000_0008, 3'h0, 32'h0, 1'b0},
    '{1'b0, 12'h32c, 32'h0, 3'h0, 32'h0000_0008, 1'b0},
    '{1'b1, 12'h328, 32'hf07f_fdfe, 3'h0, 32'h0, 1'b0},
    '{1'b0, 12'h328, 32'h0, 3'h2, 32'hf020_02a1, 1'b0},
    '{1'b0, 12'h328, 32'h0, 3'h5, 32'hf050_02a1, 1'b0},
    '{1'b0, 12'h328, 32'h0, 3'h1, 32'hf010_02a1, 1'b0},
    '{1'b0, 12'h328, 32'h0, 3'h7, 32'hf070_02a1, 1'b0},
    '{1'b0, 12'h330, 32'h0, 3'h0, 32'h0000_0000, 1'b1},
    '{1'b1, 12'h000, 32'hffff_ffff, 3'h0, 32'h0, 1'b1},
    '{1'b1, 12'h32c, 32'h0000_0000, 3'h0, 32'h0, 1'b0},
    '{1'b1, 12'h328, 32'h5000_0000, 3'h0, 32'h0, 1'b0},
    '{1'b0, 12'h328, 32'h0, 3'h0, 32'hf000_02a1, 1'b0},
    '{1'b1, 12'h32c, 32'h0000_0008, 3'h0, 32'h0, 1'b0}
  };

  switch_status_control_regs #(.FUNDAMENTAL_RESET_TRIGGER_CYCLES(2)) switch_status_control_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .operating_mode_straps(operating_mode_straps),
    .common_clock_downstream(common_clock_downstream),
    .common_clock_upstream(common_clock_upstream),
    .master_smbus_slow_select(master_smbus_slow_select),
    .reference_clock_mode(reference_clock_mode), .reset_halt_strap(reset_halt_strap),
    .upstream_lock_state(upstream_lock_state), .hot_reset(hot_reset),
    .fundamental_reset_trigger(fundamental_reset_trigger),
    .operating_mode(operating_mode), .reset_halt_active(reset_halt_active)
  );

  always #12.5 pclk = ~pclk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // called just after a rising edge; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] data, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    // answer taken at the completion edge, before that edge clears it
    data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in the same step
    @(posedge pclk);
    check("wait states", n, 0);
  endtask

  task automatic fund_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    check("trigger in reset", {31'h0, fundamental_reset_trigger}, 32'h0);
    check("mode in reset", {29'h0, operating_mode}, 32'h0);
    check("prdata in reset", prdata, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic count_trigger(input logic [31:0] d, input int exp);
    apb(1'b1, 12'h32c, d, rd, er);
    cnt = 0;
    repeat (12) begin
      @(negedge pclk);
      if (fundamental_reset_trigger === 1'b1) cnt++;
    end
    @(posedge pclk);
    check("trigger cycles", cnt, exp);
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end

  initial begin
    fund_reset();
    // straps move after capture; the status must not follow them
    operating_mode_straps <= 3'h6;
    common_clock_downstream <= 1'b0;
    common_clock_upstream <= 1'b1;
    master_smbus_slow_select <= 1'b0;
    reference_clock_mode <= 1'b1;
    reset_halt_strap <= 1'b0;
    @(posedge pclk);
    check("mode out", {29'h0, operating_mode}, {29'h0, MODE_NORMAL_EEPROM});
    check("halt out", {31'h0, reset_halt_active}, 32'h1);
    foreach (rows[i]) begin
      upstream_lock_state <= rows[i].lock;
      repeat (2) @(posedge pclk);
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
      check($sformatf("row %0d err", i), {31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].wr) check($sformatf("row %0d data", i), rd, rows[i].exp);
    end
    count_trigger(32'h0000_0009, 2);
    apb(1'b0, 12'h32c, 32'h0, rd, er);
    check("control after trigger", rd, 32'h0000_0008);
    count_trigger(32'h0000_0008, 0);
    upstream_lock_state <= 3'h3;
    repeat (2) @(posedge pclk);
    hot_reset <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h328, 32'h0, rd, er);
    check("status in hot reset", rd, 32'hf000_02a1);
    hot_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h328, 32'h0, rd, er);
    check("status after hot reset", rd, 32'hf030_02a1);
    upstream_lock_state <= 3'h0;
    fund_reset();
    check("mode second", {29'h0, operating_mode}, 32'h0000_0006);
    check("halt second", {31'h0, reset_halt_active}, 32'h0);
    apb(1'b0, 12'h328, 32'h0, rd, er);
    check("status second", rd, 32'h0000_0146);
    apb(1'b0, 12'h32c, 32'h0, rd, er);
    check("control second", rd, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
